// file: verilog/port_ctl.sv
/*
 Port power, microphone bias, boost, output level and jack detect control for
 eight bidirectional analog ports. Assumes a register port on core_clk, and
 link reset, link clock and jack sense levels arriving from outside the domain.
*/
`timescale 1ns/1ps
`include "port_ctl_defs.svh"

module port_ctl #(
	parameter int NPORT = 8,
	parameter int WAKE_LIMIT = `WAKE_LIMIT_CYC,
	parameter logic [7:0] BIAS_PORTS = 8'h17,
	parameter logic [7:0] LEVEL_PORTS = 8'h0B
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic link_rst_n,
	input wire logic link_bclk,
	input wire logic [NPORT-1:0] jack_sense,
	input wire logic pkg_large,
	output logic [NPORT*3-1:0] port_mode,
	output logic [NPORT*3-1:0] bias_sel,
	output logic [NPORT*2-1:0] boost_sel,
	output logic [NPORT-1:0] level_hi,
	output logic [NPORT-1:0] beep_route,
	output logic pwr_change_req,
	output logic unsol_req,
	output logic [NPORT-1:0] unsol_tag,
	output logic irq
);
	import port_ctl_pkg::*;

	// Elaboration checks: the register layout fixes the port count
	if (NPORT != 8) begin : g_nport_check
		$error("port_ctl supports exactly eight ports");
	end
	if (WAKE_LIMIT < 1) begin : g_limit_check
		$error("port_ctl needs a positive wake limit");
	end

	logic [2:0] pwr_r;
	logic [NPORT-1:0] in_en_r, out_en_r, level_r, present_r, unsol_tag_r;
	logic [NPORT*3-1:0] bias_r;
	logic [NPORT*2-1:0] boost_r;
	logic [3:0] stat_r, mask_r;
	logic beep_en_r, unsol_en_r, enum_done_r, unsol_r, pcr_r, late_r;
	logic [1:0] rst_sync_r, clk_sync_r;
	logic [NPORT-1:0] sense_s1_r, sense_s2_r;
	logic [1:0] pkg_sync_r;
	logic clk_prev_r;
	logic [6:0] idle_cnt_r;
	logic [31:0] wake_cnt_r;
	logic [31:0] rdata_nxt;
	logic [3:0] stat_set;
	logic link_low, jack_change;
	wake_state_e wk_r;

	// Two flip-flop synchronisers for all foreign inputs
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			rst_sync_r <= 2'h0;
			clk_sync_r <= 2'h0;
			sense_s1_r <= '0;
			sense_s2_r <= '0;
			pkg_sync_r <= 2'h0;
		end else begin
			rst_sync_r <= {rst_sync_r[0], link_rst_n};
			clk_sync_r <= {clk_sync_r[0], link_bclk};
			sense_s1_r <= jack_sense;
			sense_s2_r <= sense_s1_r;
			pkg_sync_r <= {pkg_sync_r[0], pkg_large};
		end
	end

	// Link clock activity watch; stopped clock plus reset means low power
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			clk_prev_r <= 1'b0;
			idle_cnt_r <= 7'h00;
		end else begin
			clk_prev_r <= clk_sync_r[1];
			if (clk_prev_r != clk_sync_r[1])
				idle_cnt_r <= 7'h00;
			else if (idle_cnt_r != 7'(`LINK_IDLE_CYC))
				idle_cnt_r <= idle_cnt_r + 7'h01;
		end
	end
	assign link_low = !rst_sync_r[1] && (idle_cnt_r == 7'(`LINK_IDLE_CYC));

	// Sensing runs on core_clk, independent of the link clock
	assign jack_change = (present_r != sense_s2_r) && (pwr_r <= PWR_D3);

	// Presence follows the synchronised sense lines in D0 to D3 and holds in deeper states
	always_ff @(posedge core_clk) begin
		if (sys_rst)
			present_r <= '0;
		else if (pwr_r <= PWR_D3)
			present_r <= sense_s2_r;
	end

	// Wake sequence: request while low, report after enumeration
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			wk_r <= WK_IDLE;
			pcr_r <= 1'b0;
			unsol_r <= 1'b0;
			unsol_tag_r <= '0;
			wake_cnt_r <= 32'h0;
			late_r <= 1'b0;
		end else begin
			unsol_r <= 1'b0;
			late_r <= 1'b0;
			case (wk_r)
				WK_IDLE: begin
					wake_cnt_r <= 32'h0;
					if (jack_change && link_low) begin
						wk_r <= WK_REQ;
						pcr_r <= 1'b1;
						unsol_tag_r <= present_r ^ sense_s2_r;
					end else if (jack_change && unsol_en_r && enum_done_r) begin
						unsol_r <= 1'b1;
						unsol_tag_r <= present_r ^ sense_s2_r;
					end
				end
				WK_REQ: begin
					wake_cnt_r <= wake_cnt_r + 32'h1;
					if (rst_sync_r[1]) begin
						pcr_r <= 1'b0;
						wk_r <= WK_WAIT_ENUM;
					end
				end
				WK_WAIT_ENUM: begin
					wake_cnt_r <= wake_cnt_r + 32'h1;
					if (enum_done_r) begin
						unsol_r <= 1'b1;
						wk_r <= WK_IDLE;
						late_r <= (wake_cnt_r >= 32'(WAKE_LIMIT));
					end else if (!rst_sync_r[1]) begin
						wk_r <= WK_REQ;
						pcr_r <= 1'b1;
					end
				end
				default: wk_r <= WK_IDLE;
			endcase
			if (jack_change && wk_r != WK_IDLE)
				unsol_tag_r <= unsol_tag_r | (present_r ^ sense_s2_r);
		end
	end

	// Per port operating condition from power state and enables
	always_comb begin
		for (int i = 0; i < NPORT; i++) begin
			port_mode_e m;
			m = PM_SILENT;
			case (pwr_r)
				PWR_D0, PWR_D1: begin
					if (in_en_r[i]) m = PM_INPUT;
					else if (out_en_r[i]) m = PM_OUTPUT;
					else m = PM_SILENT;
				end
				PWR_D2: begin
					if (in_en_r[i]) m = out_en_r[i] ? PM_INPUT : PM_IN_DOWN;
					else if (out_en_r[i]) m = PM_OUTPUT;
					else m = PM_SILENT;
				end
				PWR_D3: begin
					if (in_en_r[i] && out_en_r[i]) m = PM_INPUT;
					else if (out_en_r[i]) m = PM_OUT_LOW;
					else m = PM_KEEP_BIAS;
				end
				PWR_D3COLD, PWR_D4: m = PM_KEEP_BIAS;
				PWR_D5: m = PM_OFF;
				default: m = PM_OFF;
			endcase
			port_mode[i*3 +: 3] = m;
			beep_route[i] = beep_en_r && (m == PM_OUT_LOW || m == PM_OUTPUT);
		end
	end

	// Bias, boost and level drive; bias only on ports that have a pin
	always_comb begin
		for (int i = 0; i < NPORT; i++) begin
			if (BIAS_PORTS[i] && (i != 2 || pkg_sync_r[1]) && pwr_r != PWR_D5)
				bias_sel[i*3 +: 3] = bias_r[i*3 +: 3];
			else
				bias_sel[i*3 +: 3] = `BIAS_HIZ;
		end
		boost_sel = boost_r;
		level_hi = level_r & LEVEL_PORTS;
	end

	// Bias code filter: reserved codes fall to high impedance
	function automatic logic [2:0] bias_filter(input logic [2:0] c);
		if (c == `BIAS_80 || c == `BIAS_50 || c == `BIAS_GND)
			return c;
		return `BIAS_HIZ;
	endfunction

	// Software control registers
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			pwr_r <= PWR_D3;
			in_en_r <= '0;
			out_en_r <= '0;
			bias_r <= '0;
			boost_r <= '0;
			level_r <= '0;
			mask_r <= 4'h0;
			beep_en_r <= 1'b0;
			unsol_en_r <= 1'b0;
			enum_done_r <= 1'b0;
		end else begin
			if (!rst_sync_r[1])
				enum_done_r <= 1'b0;
			if (reg_wr) begin
				case (reg_addr)
					`REG_PWR: pwr_r <= (reg_wdata[2:0] > 3'(PWR_D5)) ? 3'(PWR_D5) : reg_wdata[2:0];
					`REG_PORT_EN: begin
						in_en_r <= reg_wdata[7:0];
						out_en_r <= reg_wdata[15:8];
					end
					`REG_BIAS: begin
						for (int i = 0; i < NPORT; i++)
							bias_r[i*3 +: 3] <= bias_filter(reg_wdata[i*3 +: 3]);
					end
					`REG_BOOST: boost_r <= reg_wdata[15:0];
					`REG_LEVEL: level_r <= reg_wdata[7:0] & LEVEL_PORTS;
					`REG_IRQ_MASK: mask_r <= reg_wdata[3:0];
					`REG_MODE: beep_en_r <= reg_wdata[0];
					`REG_LINK: enum_done_r <= reg_wdata[0];
					`REG_UNSOL_EN: unsol_en_r <= reg_wdata[0];
					default: ;
				endcase
			end
		end
	end

	// Sticky interrupt status, set beats write-one-to-clear
	assign stat_set = {late_r, unsol_r, wk_r == WK_IDLE && jack_change && link_low, jack_change};
	always_ff @(posedge core_clk) begin
		if (sys_rst)
			stat_r <= 4'h0;
		else if (reg_wr && reg_addr == `REG_IRQ_STAT)
			stat_r <= (stat_r & ~reg_wdata[3:0]) | stat_set;
		else
			stat_r <= stat_r | stat_set;
	end
	assign irq = |(stat_r & mask_r);

	// Read mux
	always_comb begin
		rdata_nxt = 32'h0;
		case (reg_addr)
			`REG_PWR: rdata_nxt = {29'h0, pwr_r};
			`REG_PORT_EN: rdata_nxt = {16'h0, out_en_r, in_en_r};
			`REG_BIAS: rdata_nxt = {8'h0, bias_r};
			`REG_BOOST: rdata_nxt = {16'h0, boost_r};
			`REG_LEVEL: rdata_nxt = {24'h0, level_r};
			`REG_PRESENT: rdata_nxt = {24'h0, present_r};
			`REG_IRQ_STAT: rdata_nxt = {28'h0, stat_r};
			`REG_IRQ_MASK: rdata_nxt = {28'h0, mask_r};
			`REG_MODE: rdata_nxt = {31'h0, beep_en_r};
			`REG_LINK: rdata_nxt = {29'h0, link_low, pcr_r, enum_done_r};
			`REG_UNSOL_EN: rdata_nxt = {31'h0, unsol_en_r};
			default: rdata_nxt = 32'h0;
		endcase
	end

	// Registered read data, valid the cycle after the strobe
	always_ff @(posedge core_clk) begin
		if (sys_rst)
			reg_rdata <= 32'h0;
		else if (reg_rd)
			reg_rdata <= rdata_nxt;
		else
			reg_rdata <= 32'h0;
	end

	assign pwr_change_req = pcr_r;
	assign unsol_req = unsol_r;
	assign unsol_tag = unsol_tag_r;

	// Checks next to the logic
	a_both_en_input: assert property (@(posedge core_clk) disable iff (sys_rst)
		(pwr_r <= PWR_D3 && in_en_r[0] && out_en_r[0]) |-> port_mode[2:0] == PM_INPUT)
		else $error("both enables did not give input");
	a_d5_all_off: assert property (@(posedge core_clk) disable iff (sys_rst)
		pwr_r == PWR_D5 |-> port_mode == {NPORT{PM_OFF}} && bias_sel == '0)
		else $error("port not off in D5");
	a_d2_in_down: assert property (@(posedge core_clk) disable iff (sys_rst)
		(pwr_r == PWR_D2 && in_en_r[1] && !out_en_r[1]) |-> port_mode[5:3] == PM_IN_DOWN)
		else $error("D2 input not powered down");
	a_d3_keep_bias: assert property (@(posedge core_clk) disable iff (sys_rst)
		(pwr_r == PWR_D3COLD || pwr_r == PWR_D4) |-> port_mode[2:0] == PM_KEEP_BIAS)
		else $error("coupling bias not kept");
	a_bias_legal: assert property (@(posedge core_clk) disable iff (sys_rst)
		reg_wr && reg_addr == `REG_BIAS && reg_wdata[2:0] == 3'h7 |=> bias_r[2:0] == `BIAS_HIZ)
		else $error("reserved bias code kept");
	a_no_bias_pin: assert property (@(posedge core_clk) disable iff (sys_rst)
		bias_sel[23:15] == '0 && bias_sel[11:9] == '0)
		else $error("bias on port without pin");
	a_wake_request: assert property (@(posedge core_clk) disable iff (sys_rst)
		(wk_r == WK_IDLE && jack_change && link_low) |=> pwr_change_req && unsol_tag != '0)
		else $error("no wake request on change");
	a_wake_report: assert property (@(posedge core_clk) disable iff (sys_rst)
		(wk_r == WK_WAIT_ENUM && enum_done_r) |=> unsol_req ##1 !unsol_req)
		else $error("no report after enumeration");
	a_beep_d3: assert property (@(posedge core_clk) disable iff (sys_rst)
		(pwr_r == PWR_D3 && out_en_r[3] && !in_en_r[3]) |-> beep_route[3] == beep_en_r)
		else $error("beep not routed in D3");
	a_d01_output: assert property (@(posedge core_clk) disable iff (sys_rst)
		(pwr_r <= PWR_D1 && out_en_r[1] && !in_en_r[1]) |-> port_mode[5:3] == PM_OUTPUT)
		else $error("output-only port not active in D0 or D1");
	a_idle_silent: assert property (@(posedge core_clk) disable iff (sys_rst)
		(pwr_r <= PWR_D2 && !in_en_r[3] && !out_en_r[3]) |-> port_mode[11:9] == PM_SILENT)
		else $error("idle port not driving silence");
	a_small_pkg_c: assert property (@(posedge core_clk) disable iff (sys_rst)
		!pkg_sync_r[1] |-> bias_sel[8:6] == `BIAS_HIZ)
		else $error("port C bias in small package");
	a_boost_pass: assert property (@(posedge core_clk) disable iff (sys_rst)
		(reg_wr && reg_addr == `REG_BOOST) |=> boost_sel == 16'($past(reg_wdata)))
		else $error("boost setting not applied");
	a_level_mask: assert property (@(posedge core_clk) disable iff (sys_rst)
		(reg_wr && reg_addr == `REG_LEVEL) |=> level_hi == (8'($past(reg_wdata)) & LEVEL_PORTS))
		else $error("raised level not applied");
	a_active_unsol: assert property (@(posedge core_clk) disable iff (sys_rst)
		(wk_r == WK_IDLE && jack_change && !link_low && unsol_en_r && enum_done_r)
		|=> unsol_req && !pwr_change_req)
		else $error("no direct report with link active");
endmodule

// file: verilog/port_ctl_defs.svh
/*
 Constants for the port power and jack detect controller: register offsets,
 field codes and timing counts. Assumes a 20 MHz core clock.
*/
`ifndef PORT_CTL_DEFS_SVH
`define PORT_CTL_DEFS_SVH

// Register word offsets
`define REG_PWR 8'h00
`define REG_PORT_EN 8'h04
`define REG_BIAS 8'h08
`define REG_BOOST 8'h0C
`define REG_LEVEL 8'h10
`define REG_PRESENT 8'h14
`define REG_IRQ_STAT 8'h18
`define REG_IRQ_MASK 8'h1C
`define REG_MODE 8'h20
`define REG_LINK 8'h24
`define REG_UNSOL_EN 8'h28

// Bias selector codes, three bits per port
`define BIAS_HIZ 3'h0
`define BIAS_50 3'h1
`define BIAS_GND 3'h2
`define BIAS_80 3'h4

// Interrupt status bits
`define IRQ_JACK 0
`define IRQ_WAKE 1
`define IRQ_UNSOL 2
`define IRQ_LATE 3

// Wake to report deadline
`define WAKE_LIMIT_US 10000
`define CLK_MHZ 20
`define WAKE_LIMIT_CYC (`WAKE_LIMIT_US * `CLK_MHZ)
// Link clock considered stopped after this many core cycles without an edge
`define LINK_IDLE_CYC 64
`endif

// file: verilog/port_ctl_pkg.sv
/*
 Types for the port power and jack detect controller.
 Assumes port_ctl_defs.svh is compiled alongside.
*/
package port_ctl_pkg;
	typedef enum logic [2:0] {
		PWR_D0 = 3'b000,
		PWR_D1 = 3'b001,
		PWR_D2 = 3'b010,
		PWR_D3 = 3'b011,
		PWR_D3COLD = 3'b100,
		PWR_D4 = 3'b101,
		PWR_D5 = 3'b110
	} pwr_state_e;

	typedef enum logic [2:0] {
		PM_SILENT = 3'b000,
		PM_INPUT = 3'b001,
		PM_OUTPUT = 3'b010,
		PM_IN_DOWN = 3'b011,
		PM_OUT_LOW = 3'b100,
		PM_KEEP_BIAS = 3'b101,
		PM_OFF = 3'b110
	} port_mode_e;

	typedef enum logic [1:0] {
		WK_IDLE = 2'b00,
		WK_REQ = 2'b01,
		WK_WAIT_ENUM = 2'b10
	} wake_state_e;
endpackage

// file: verif/link_host_model.sv
/*
 Controller side of the link: drives link reset and the 400 ns bit clock.
 Assumes the bench commands sleep and the block raises its wake request.
*/
`timescale 1ns/1ps
module link_host_model #(
	parameter int WAKE_DLY_NS = 2000
) (
	input wire logic sleep_cmd,
	input wire logic pwr_change_req,
	output logic link_rst_n,
	output logic link_bclk
);
	logic run;

	// Bit clock, standing low while the link sleeps
	initial begin
		link_bclk = 1'b0;
		forever begin
			#200;
			link_bclk = run ? ~link_bclk : 1'b0;
		end
	end

	// Power up: clock first, reset released later
	initial begin
		run = 1'b1;
		link_rst_n = 1'b0;
		#800 link_rst_n = 1'b1;
	end

	// Low power entry: reset asserted, then clock stopped
	always @(posedge sleep_cmd) begin
		link_rst_n = 1'b0;
		#400 run = 1'b0;
	end

	// Wake the link when the block asks for it
	always @(posedge pwr_change_req) begin
		if (!run) begin
			#WAKE_DLY_NS run = 1'b1;
			#800 link_rst_n = 1'b1;
		end
	end
endmodule

// file: verif/test_port_ctl.sv
/*
 Bench for port_ctl: power table, bias, boost, level, jack change and wake.
 Assumes link_host_model on the link side and a 20 MHz core clock.
*/
`timescale 1ns/1ps
`include "port_ctl_defs.svh"
module test_port_ctl;
	import port_ctl_pkg::*;
	logic core_clk, sys_rst, reg_wr, reg_rd, pkg_large, sleep_cmd;
	logic link_rst_n, link_bclk, pwr_change_req, unsol_req, irq;
	logic [7:0] reg_addr, jack_sense, level_hi, beep_route, unsol_tag;
	logic [31:0] reg_wdata, reg_rdata, rd;
	logic [23:0] port_mode, bias_sel, eb;
	logic [15:0] boost_sel;
	logic [2:0] m;
	int failures, tests_run;

	port_ctl #(.WAKE_LIMIT(200)) dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.link_rst_n(link_rst_n), .link_bclk(link_bclk), .jack_sense(jack_sense), .pkg_large(pkg_large),
		.port_mode(port_mode), .bias_sel(bias_sel), .boost_sel(boost_sel), .level_hi(level_hi),
		.beep_route(beep_route), .pwr_change_req(pwr_change_req), .unsol_req(unsol_req),
		.unsol_tag(unsol_tag), .irq(irq));
	link_host_model host_u (.sleep_cmd(sleep_cmd), .pwr_change_req(pwr_change_req),
		.link_rst_n(link_rst_n), .link_bclk(link_bclk));

	// Core clock, 50 ns period
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end

	// Register bus cycles
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		#1;
	endtask
	task automatic rdr(input logic [7:0] a);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 rd = reg_rdata;
	endtask

	// Value comparison
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] t=%0t got %h exp %h", $time, g, e);
		end
	endtask

	// Expected port mode for power state and enables
	function automatic logic [2:0] em(input int p, input bit i, input bit o);
		if (p >= 6) return PM_OFF;
		if (p > 3) return PM_KEEP_BIAS;
		if (i && o) return PM_INPUT;
		if (i) return p < 2 ? PM_INPUT : (p == 2 ? PM_IN_DOWN : PM_KEEP_BIAS);
		if (o) return p < 3 ? PM_OUTPUT : PM_OUT_LOW;
		return p < 3 ? PM_SILENT : PM_KEEP_BIAS;
	endfunction

	// Bounded wait on request (s=0) or response (s=1)
	task automatic hold_until(input int s, input logic v);
		int n;
		for (n = 0; n < 400; n++) begin
			if ((s == 0 ? pwr_change_req : unsol_req) === v) break;
			@(posedge core_clk);
			#1;
		end
		if (n == 400) begin
			failures++;
			$display("[FAIL] t=%0t got %h exp %h", $time, ~v, v);
			tally_and_finish;
		end
	endtask

	task automatic done(input string s);
		$display("test %s done", s);
	endtask

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	// Main sequence
	initial begin
		int c, p, k;
		failures = 0;
		tests_run = 0;
		sys_rst = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		jack_sense = 8'h00;
		pkg_large = 1'b1;
		sleep_cmd = 1'b0;
		repeat (2) @(posedge core_clk);
		sys_rst <= 1'b0;
		#1;
		for (k = 0; k < 8; k++) chk(port_mode[3*k+:3], PM_KEEP_BIAS);
		rdr(`REG_PWR);
		chk(rd, 32'h3);
		done("reset");
		wr(`REG_PWR, 32'h0);
		for (c = 0; c < 8; c++) begin
			wr(`REG_BIAS, c);
			rdr(`REG_BIAS);
			chk(rd[2:0], (c == 1 || c == 2 || c == 4) ? c : 0);
			chk(bias_sel[2:0], (c == 1 || c == 2 || c == 4) ? c : 0);
		end
		for (c = 0; c < 2; c++) begin
			@(posedge core_clk);
			pkg_large <= c[0];
			wr(`REG_BIAS, 32'h924924);
			eb = 24'h0;
			for (k = 0; k < 8; k++) if ((c ? 8'h17 : 8'h13) >> k & 1) eb[3*k+:3] = `BIAS_80;
			chk(bias_sel, eb);
		end
		done("bias");
		wr(`REG_BOOST, 32'hE4E4);
		chk(boost_sel, 16'hE4E4);
		wr(`REG_LEVEL, 32'hFF);
		chk(level_hi, 8'h0B);
		done("boost_level");
		wr(`REG_MODE, 32'h1);
		wr(`REG_PORT_EN, 32'h0605);
		for (p = 0; p < 8; p++) begin
			wr(`REG_PWR, p);
			for (k = 0; k < 4; k++) begin
				m = em(p, 5 >> k & 1, 6 >> k & 1);
				chk(port_mode[3*k+:3], m);
				chk(beep_route[k], m == PM_OUTPUT || m == PM_OUT_LOW);
			end
		end
		chk(bias_sel, 24'h0);
		done("power_table");
		wr(`REG_PWR, 32'h0);
		wr(`REG_LINK, 32'h1);
		wr(`REG_UNSOL_EN, 32'h1);
		wr(`REG_IRQ_MASK, 32'h0);
		@(posedge core_clk);
		jack_sense <= 8'h02;
		hold_until(1, 1'b1);
		chk(unsol_tag, 8'h02);
		chk(pwr_change_req, 1'b0);
		chk(irq, 1'b0);
		rdr(`REG_PRESENT);
		chk(rd, 32'h2);
		wr(`REG_IRQ_MASK, 32'h1);
		rdr(`REG_IRQ_STAT);
		chk(rd, 32'h5);
		chk(irq, 1'b1);
		wr(`REG_IRQ_STAT, 32'hF);
		rdr(`REG_IRQ_STAT);
		chk(rd, 32'h0);
		chk(irq, 1'b0);
		done("jack_active");
		wr(`REG_PWR, 32'h3);
		@(posedge core_clk);
		sleep_cmd <= 1'b1;
		repeat (90) @(posedge core_clk);
		rdr(`REG_LINK);
		chk(rd, 32'h4);
		@(posedge core_clk);
		jack_sense <= 8'h03;
		hold_until(0, 1'b1);
		hold_until(0, 1'b0);
		@(posedge core_clk);
		sleep_cmd <= 1'b0;
		wr(`REG_LINK, 32'h1);
		hold_until(1, 1'b1);
		chk(unsol_tag, 8'h01);
		rdr(`REG_IRQ_STAT);
		chk(rd, 32'h7);
		done("wake");
		tally_and_finish;
	end
endmodule
